// ===== rtl/dsad_map.svh
/*
 * Address map and constants for the data-space address decoder.
 * Assumes it is included by bare name from the package and the design modules.
 */
`ifndef DSAD_MAP_SVH
`define DSAD_MAP_SVH

// ----------------------------------------------------------------------
// Data-space regions
// ----------------------------------------------------------------------
`define DSAD_ADDR_W 16
`define DSAD_MMR_LAST 16'h005f
`define DSAD_GLOBAL_ALLOC_REG_ADDR 16'h0005
`define DSAD_B2_FIRST 16'h0060
`define DSAD_B2_LAST 16'h007f
`define DSAD_B0_FIRST 16'h0200
`define DSAD_B0_LAST 16'h02ff
`define DSAD_B1_FIRST 16'h0300
`define DSAD_B1_LAST 16'h03ff
`define DSAD_RESV_A_LAST 16'h07ff
`define DSAD_FRAME1_FIRST 16'h7000
`define DSAD_FRAME1_LAST 16'h73ff
`define DSAD_FRAME2_FIRST 16'h7400
`define DSAD_FRAME2_LAST 16'h743f
`define DSAD_RESV_B_FIRST 16'h7440
`define DSAD_RESV_B_LAST 16'h77ff
`define DSAD_EXT_FIRST 16'h8000

// ----------------------------------------------------------------------
// Peripheral frame 1 sub-ranges (address bits 9:4 inside the frame)
// ----------------------------------------------------------------------
`define DSAD_SUB_LSB 4
`define DSAD_SUB_MSB 9
`define DSAD_SUB_SYS 6'h01
`define DSAD_SUB_WDOG 6'h02
`define DSAD_SUB_ADC 6'h03
`define DSAD_SUB_SPI 6'h04
`define DSAD_SUB_SCI 6'h05
`define DSAD_SUB_XINT 6'h07
`define DSAD_SUB_DIO 6'h09

// ----------------------------------------------------------------------
// Global memory allocation register
// ----------------------------------------------------------------------
`define DSAD_GLOBAL_ALLOC_REG_RESET 16'h0000
`define DSAD_GMASK_MSB 7
`define DSAD_GMASK_W 8
`define DSAD_GMASK_ENABLE_BIT 7

`endif

// ===== rtl/dsad_pkg.sv
/*
 * Types shared by the data-space address decoder modules.
 * Assumes dsad_map.svh is on the include path.
 */
`include "dsad_map.svh"

package dsad_pkg;

    typedef enum logic [1:0] {SPACE_PROG, SPACE_DATA, SPACE_IO} space_t;

    typedef enum logic [2:0] {
        PER_NONE, PER_SYS, PER_WDOG, PER_ADC, PER_SPI, PER_SCI, PER_XINT, PER_DIO
    } periph_t;

    typedef enum logic [2:0] {
        REG_MMR, REG_RAM, REG_RESV, REG_ILLEGAL, REG_FRAME1, REG_FRAME2, REG_EXT
    } region_t;

    typedef enum {ST_IDLE, ST_GRANT_WAIT} state_t;

endpackage : dsad_pkg

// ===== rtl/periph_frame_decode.sv
/*
 * Combinational sub-range decoder for the system and peripheral frame.
 * Assumes the caller only trusts the result for addresses inside that frame.
 */
`timescale 1ns/1ns
`include "dsad_map.svh"

module periph_frame_decode
    import dsad_pkg::*;
(
    // Address in
    input wire logic [`DSAD_ADDR_W-1:0] i_addr,
    // Decode out
    output periph_t o_periph,
    output logic o_gap
);

    logic [`DSAD_SUB_MSB-`DSAD_SUB_LSB:0] sub;

    assign sub = i_addr[`DSAD_SUB_MSB:`DSAD_SUB_LSB];

    always_comb begin
        o_gap = 1'b0;
        if (sub == `DSAD_SUB_SYS) begin // [RULE_06]
            o_periph = PER_SYS;
        end else if (sub == `DSAD_SUB_WDOG) begin
            o_periph = PER_WDOG;
        end else if (sub == `DSAD_SUB_ADC) begin
            o_periph = PER_ADC;
        end else if (sub == `DSAD_SUB_SPI) begin
            o_periph = PER_SPI;
        end else if (sub == `DSAD_SUB_SCI) begin
            o_periph = PER_SCI;
        end else if (sub == `DSAD_SUB_XINT) begin
            o_periph = PER_XINT;
        end else if (sub == `DSAD_SUB_DIO) begin
            o_periph = PER_DIO;
        end else begin
            // Gaps, including everything after the digital I/O block up to the frame end.
            o_periph = PER_NONE;
            o_gap = 1'b1; // [RULE_06]
        end
    end

endmodule : periph_frame_decode

// ===== rtl/data_space_address_decoder.sv
/*
 * Data-space address decoder: routes CPU accesses to core registers, RAM,
 * peripheral frames, external memory and the global memory region, and
 * arbitrates global accesses through a bus request and a grant pin.
 * Assumes the CPU holds its request until o_ready was high at the taking edge,
 * and that the grant arrives from outside the clock domain.
 */
`timescale 1ns/1ns
`include "dsad_map.svh"

// Overview of operation
// [RULE_01] Program, data and I/O spaces kept apart.
// [RULE_02] Top data region is global, power-of-two sized.
// [RULE_03] Bus request raised before any global access.
// [RULE_04] Lowest 96 data words go to core registers.
// [RULE_05] Peripherals reachable only through data-space accesses.
// [RULE_06] Peripheral frame split into 16-word sub-ranges.
// [RULE_07] One select per access; illegal ranges flagged.
module data_space_address_decoder
    import dsad_pkg::*;
#(
    parameter int ADDR_W = `DSAD_ADDR_W,
    parameter int DATA_W = 16
) (
    // Clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // CPU access
    input wire logic i_req,
    input space_t i_space,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_we,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_cnf,
    output logic o_ready,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_rdata_valid,
    // Routed access
    output logic [ADDR_W-1:0] o_addr,
    output logic o_we,
    output logic [DATA_W-1:0] o_wdata,
    output logic o_sel_prog,
    output logic o_sel_io,
    output logic o_sel_mmr,
    output logic o_sel_ram,
    output logic o_sel_frame1,
    output periph_t o_periph,
    output logic o_sel_frame2,
    output logic o_sel_ext,
    output logic o_sel_global,
    output logic o_reserved,
    output logic o_illegal,
    // Global memory arbitration
    output logic o_global_bus_request,
    input wire logic i_global_grant,
    output logic [DATA_W-1:0] o_global_alloc_reg
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] lo,
                                      input logic [ADDR_W-1:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // A contiguous mask of ones from bit 7 downward selects 32K..256 words.
    // Bit 7 clear means no global region, so low memory can never turn global.
    function automatic logic is_global(input logic [ADDR_W-1:0] a,
                                       input logic [DATA_W-1:0] global_alloc_reg);
        logic [`DSAD_GMASK_MSB:0] m;
        m = global_alloc_reg[`DSAD_GMASK_MSB:0];
        is_global = m[`DSAD_GMASK_ENABLE_BIT] &&
                    ((a[ADDR_W-1 -: `DSAD_GMASK_W] & m) == m); // [RULE_02]
    endfunction : is_global

    function automatic region_t decode_region(input logic [ADDR_W-1:0] a,
                                              input logic cnf);
        if (a <= `DSAD_MMR_LAST) begin
            decode_region = REG_MMR; // [RULE_04]
        end else if (in_range(a, `DSAD_B2_FIRST, `DSAD_B2_LAST)) begin
            decode_region = REG_RAM;
        end else if (in_range(a, `DSAD_B0_FIRST, `DSAD_B0_LAST)) begin
            decode_region = cnf ? REG_RESV : REG_RAM;
        end else if (in_range(a, `DSAD_B1_FIRST, `DSAD_B1_LAST)) begin
            decode_region = REG_RAM;
        end else if (a <= `DSAD_RESV_A_LAST) begin
            decode_region = REG_RESV;
        end else if (in_range(a, `DSAD_FRAME1_FIRST, `DSAD_FRAME1_LAST)) begin
            decode_region = REG_FRAME1;
        end else if (in_range(a, `DSAD_FRAME2_FIRST, `DSAD_FRAME2_LAST)) begin
            decode_region = REG_FRAME2;
        end else if (in_range(a, `DSAD_RESV_B_FIRST, `DSAD_RESV_B_LAST)) begin
            decode_region = REG_RESV;
        end else if (a >= `DSAD_EXT_FIRST) begin
            decode_region = REG_EXT;
        end else begin
            decode_region = REG_ILLEGAL;
        end
    endfunction : decode_region

    // ------------------------------------------------------------------
    // Grant synchroniser
    // ------------------------------------------------------------------
    logic grant_meta;
    logic grant_sync;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            grant_meta <= 1'b0;
            grant_sync <= 1'b0;
        end else if (i_ce) begin
            grant_meta <= i_global_grant;
            grant_sync <= grant_meta;
        end
    end

    // ------------------------------------------------------------------
    // Frame sub-range decode
    // ------------------------------------------------------------------
    periph_t frame_periph;
    logic frame_gap;

    periph_frame_decode u_frame (
        .i_addr(i_addr),
        .o_periph(frame_periph),
        .o_gap(frame_gap)
    );

    // ------------------------------------------------------------------
    // Access state and routed outputs
    // ------------------------------------------------------------------
    state_t state, next_state;
    logic [DATA_W-1:0] global_alloc_reg, next_global_alloc_reg;
    logic next_ready, next_rdata_valid, next_we, next_bus_request;
    logic grant_clear, next_grant_clear;
    logic [DATA_W-1:0] next_rdata, next_wdata;
    logic [ADDR_W-1:0] next_addr;
    logic next_sel_prog, next_sel_io, next_sel_mmr, next_sel_ram, next_sel_frame1;
    logic next_sel_frame2, next_sel_ext, next_sel_global, next_reserved, next_illegal;
    periph_t next_periph;
    region_t region;
    logic take;

    assign take = i_req && o_ready;
    assign region = decode_region(i_addr, i_cnf);

    always_comb begin
        next_state = state;
        next_global_alloc_reg = global_alloc_reg;
        next_ready = o_ready;
        next_rdata = o_rdata;
        next_rdata_valid = 1'b0;
        next_addr = o_addr;
        next_we = o_we;
        next_wdata = o_wdata;
        next_bus_request = o_global_bus_request;
        next_grant_clear = grant_clear;
        next_sel_prog = 1'b0;
        next_sel_io = 1'b0;
        next_sel_mmr = 1'b0;
        next_sel_ram = 1'b0;
        next_sel_frame1 = 1'b0;
        next_periph = PER_NONE;
        next_sel_frame2 = 1'b0;
        next_sel_ext = 1'b0;
        next_sel_global = 1'b0;
        next_reserved = 1'b0;
        next_illegal = 1'b0;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_addr = i_addr;
                    next_we = i_we;
                    next_wdata = i_wdata;
                    if (i_space == SPACE_PROG) begin
                        next_sel_prog = 1'b1; // [RULE_01]
                    end else if (i_space == SPACE_IO) begin
                        next_sel_io = 1'b1; // [RULE_01]
                    end else if (is_global(i_addr, global_alloc_reg)) begin
                        // The access waits here until the bus owner grants it.
                        next_bus_request = 1'b1; // [RULE_03]
                        next_ready = 1'b0;
                        next_state = ST_GRANT_WAIT;
                        next_grant_clear = 1'b0;
                    end else begin
                        // Exactly one select or one flag per access.
                        case (region) // [RULE_07]
                            REG_MMR: begin
                                next_sel_mmr = 1'b1; // [RULE_04]
                                if (i_addr == `DSAD_GLOBAL_ALLOC_REG_ADDR) begin
                                    if (i_we) begin
                                        next_global_alloc_reg = i_wdata; // [RULE_02]
                                    end else begin
                                        next_rdata = global_alloc_reg;
                                        next_rdata_valid = 1'b1;
                                    end
                                end
                            end
                            REG_RAM: next_sel_ram = 1'b1;
                            REG_FRAME1: begin
                                next_sel_frame1 = !frame_gap; // [RULE_05]
                                next_periph = frame_periph; // [RULE_06]
                                next_illegal = frame_gap; // [RULE_07]
                            end
                            REG_FRAME2: next_sel_frame2 = 1'b1; // [RULE_05]
                            REG_EXT: next_sel_ext = 1'b1;
                            REG_RESV: next_reserved = 1'b1;
                            default: next_illegal = 1'b1; // [RULE_07]
                        endcase
                    end
                end
            end
            ST_GRANT_WAIT: begin
                // A grant left up by the previous access must fall before one is honoured.
                if (!grant_sync) begin
                    next_grant_clear = 1'b1;
                end
                if (grant_sync && grant_clear) begin
                    next_sel_global = 1'b1; // [RULE_03]
                    next_bus_request = 1'b0;
                    next_ready = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= ST_IDLE;
            global_alloc_reg <= `DSAD_GLOBAL_ALLOC_REG_RESET;
            grant_clear <= 1'b0;
            o_ready <= 1'b1;
            o_rdata <= '0;
            o_rdata_valid <= 1'b0;
            o_addr <= '0;
            o_we <= 1'b0;
            o_wdata <= '0;
            o_global_bus_request <= 1'b0;
            o_sel_prog <= 1'b0;
            o_sel_io <= 1'b0;
            o_sel_mmr <= 1'b0;
            o_sel_ram <= 1'b0;
            o_sel_frame1 <= 1'b0;
            o_periph <= PER_NONE;
            o_sel_frame2 <= 1'b0;
            o_sel_ext <= 1'b0;
            o_sel_global <= 1'b0;
            o_reserved <= 1'b0;
            o_illegal <= 1'b0;
            o_global_alloc_reg <= `DSAD_GLOBAL_ALLOC_REG_RESET;
        end else if (i_ce) begin
            state <= next_state;
            global_alloc_reg <= next_global_alloc_reg;
            grant_clear <= next_grant_clear;
            o_ready <= next_ready;
            o_rdata <= next_rdata;
            o_rdata_valid <= next_rdata_valid;
            o_addr <= next_addr;
            o_we <= next_we;
            o_wdata <= next_wdata;
            o_global_bus_request <= next_bus_request;
            o_sel_prog <= next_sel_prog;
            o_sel_io <= next_sel_io;
            o_sel_mmr <= next_sel_mmr;
            o_sel_ram <= next_sel_ram;
            o_sel_frame1 <= next_sel_frame1;
            o_periph <= next_periph;
            o_sel_frame2 <= next_sel_frame2;
            o_sel_ext <= next_sel_ext;
            o_sel_global <= next_sel_global;
            o_reserved <= next_reserved;
            o_illegal <= next_illegal;
            o_global_alloc_reg <= next_global_alloc_reg;
        end
    end

endmodule : data_space_address_decoder

// ===== dv/dsad_chk.sv
/*
 * Concurrent checks for the data-space address decoder.
 * Assumes it is bound to the decoder top and sees only its ports.
 */
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Checker
// ----------------------------------------------------------------------
module dsad_chk
    import dsad_pkg::*;
(
    // Clock and access
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_req,
    input space_t i_space,
    input wire logic [15:0] i_addr,
    input wire logic i_we,
    // Decoder answers
    input wire logic o_ready,
    input wire logic [15:0] o_rdata,
    input wire logic o_rdata_valid,
    input wire logic o_sel_prog,
    input wire logic o_sel_io,
    input wire logic o_sel_mmr,
    input wire logic o_sel_ram,
    input wire logic o_sel_frame1,
    input periph_t o_periph,
    input wire logic o_sel_frame2,
    input wire logic o_sel_ext,
    input wire logic o_sel_global,
    input wire logic o_reserved,
    input wire logic o_illegal,
    input wire logic o_global_bus_request,
    input wire logic [15:0] o_global_alloc_reg
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    logic [7:0] gm;
    assign gm = o_global_alloc_reg[7:0];

    sequence s_take;
        i_ce && i_req && o_ready;
    endsequence
    sequence s_take_data;
        s_take ##0 i_space == SPACE_DATA;
    endsequence
    sequence s_wait;
        o_global_bus_request && !o_ready;
    endsequence

    property p_prog;
        s_take ##0 i_space == SPACE_PROG |=> o_sel_prog;
    endproperty
    a_prog: assert property (p_prog) else $error("program access not kept apart");
    property p_noper;
        s_take ##0 i_space != SPACE_DATA |=> !o_sel_frame1 && !o_sel_frame2;
    endproperty
    a_noper: assert property (p_noper) else $error("frame selected outside data");
    property p_glob;
        s_take_data ##0 (gm[7] && (i_addr[15:8] & gm) == gm) |=> s_wait ##0 !o_sel_ext;
    endproperty
    a_glob: assert property (p_glob) else $error("global access not requested");
    property p_greq;
        o_sel_global |-> $past(o_global_bus_request);
    endproperty
    a_greq: assert property (p_greq) else $error("global select without request");
    property p_mmr;
        s_take_data ##0 i_addr <= 16'h005f |=> o_sel_mmr;
    endproperty
    a_mmr: assert property (p_mmr) else $error("low data word not to registers");
    property p_spi;
        s_take_data ##0 (i_addr[15:10] == 6'h1c && i_addr[9:4] == 6'h04)
            |=> o_sel_frame1 && o_periph == PER_SPI;
    endproperty
    a_spi: assert property (p_spi) else $error("sub-range decode wrong");
    property p_gap;
        s_take_data ##0 (i_addr[15:10] == 6'h1c
            && !(i_addr[9:4] inside {6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h07, 6'h09}))
            |=> o_illegal;
    endproperty
    a_gap: assert property (p_gap) else $error("frame gap not flagged");
    property p_ill;
        s_take_data ##0 i_addr inside {[16'h0800:16'h6fff]} |=> o_illegal && !o_sel_ram;
    endproperty
    a_ill: assert property (p_ill) else $error("illegal range not flagged");
    property p_one;
        $onehot0({o_sel_prog, o_sel_io, o_sel_mmr, o_sel_ram, o_sel_frame1, o_sel_frame2,
            o_sel_ext, o_sel_global, o_reserved, o_illegal});
    endproperty
    a_one: assert property (p_one) else $error("more than one select");
    property p_rd;
        s_take_data ##0 (i_addr == 16'h0005 && !i_we)
            |=> o_rdata_valid && o_rdata == o_global_alloc_reg;
    endproperty
    a_rd: assert property (p_rd) else $error("allocation read wrong");
endmodule : dsad_chk

bind data_space_address_decoder dsad_chk i_chk (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_req(i_req), .i_space(i_space),
    .i_addr(i_addr), .i_we(i_we), .o_ready(o_ready), .o_rdata(o_rdata),
    .o_rdata_valid(o_rdata_valid), .o_sel_prog(o_sel_prog), .o_sel_io(o_sel_io),
    .o_sel_mmr(o_sel_mmr), .o_sel_ram(o_sel_ram), .o_sel_frame1(o_sel_frame1),
    .o_periph(o_periph), .o_sel_frame2(o_sel_frame2), .o_sel_ext(o_sel_ext),
    .o_sel_global(o_sel_global), .o_reserved(o_reserved), .o_illegal(o_illegal),
    .o_global_bus_request(o_global_bus_request), .o_global_alloc_reg(o_global_alloc_reg)
);

// ===== dv/global_bus_owner.sv
/*
 * Behavioural owner of the external global bus: grants after a latency.
 * Assumes the request is a level that stays up until the access is done.
 */
`timescale 1ns/1ns
module global_bus_owner (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Arbitration
    input wire logic i_request,
    input wire logic [3:0] i_lat,
    output logic o_grant
);
    int cnt;
    // Grant is dropped on the first edge that sees the request low, so a stale grant can still reach the next access.
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= 0;
            o_grant <= 1'b0;
        end else if (!i_request) begin
            cnt <= 0;
            o_grant <= #1 1'b0;
        end else if (cnt >= i_lat) begin
            o_grant <= #1 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : global_bus_owner

// ===== dv/data_space_address_decoder_bench.sv
/*
 * Self-checking bench for the data-space address decoder.
 * Assumes the checker is bound and the bus owner model answers grants.
 */
`timescale 1ns/1ns
module data_space_address_decoder_bench;
    import dsad_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst_b, i_ce, i_req, i_we, i_cnf, o_ready, o_rdata_valid, o_we;
    logic o_sel_prog, o_sel_io, o_sel_mmr, o_sel_ram, o_sel_frame1, o_sel_frame2;
    logic o_sel_ext, o_sel_global, o_reserved, o_illegal, o_global_bus_request, i_global_grant;
    logic [15:0] i_addr, i_wdata, o_rdata, o_addr, o_wdata, o_global_alloc_reg;
    logic [3:0] lat;
    logic [9:0] sv;
    space_t i_space;
    periph_t o_periph;
    int n_mismatch = 0;
    int num_checks = 0;

    always #5 i_mclk = ~i_mclk;
    assign sv = {o_sel_prog, o_sel_io, o_sel_mmr, o_sel_ram, o_sel_frame1, o_sel_frame2,
        o_sel_ext, o_sel_global, o_reserved, o_illegal};

    data_space_address_decoder i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(i_ce),
        .i_req(i_req), .i_space(i_space), .i_addr(i_addr), .i_we(i_we), .i_wdata(i_wdata),
        .i_cnf(i_cnf), .o_ready(o_ready), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid),
        .o_addr(o_addr), .o_we(o_we), .o_wdata(o_wdata), .o_sel_prog(o_sel_prog),
        .o_sel_io(o_sel_io), .o_sel_mmr(o_sel_mmr), .o_sel_ram(o_sel_ram),
        .o_sel_frame1(o_sel_frame1), .o_periph(o_periph), .o_sel_frame2(o_sel_frame2),
        .o_sel_ext(o_sel_ext), .o_sel_global(o_sel_global), .o_reserved(o_reserved),
        .o_illegal(o_illegal), .o_global_bus_request(o_global_bus_request),
        .i_global_grant(i_global_grant), .o_global_alloc_reg(o_global_alloc_reg));
    global_bus_owner i_owner (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_request(o_global_bus_request), .i_lat(lat), .o_grant(i_global_grant));

    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task results;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    // Request is held across back-to-back takes; only a global wait drops it.
    task go(input space_t sp, input logic [15:0] a, input logic we, input logic [9:0] ev,
            input periph_t ep);
        int n;
        i_space = sp;
        i_addr = a;
        i_we = we;
        i_req = 1'b1;
        @(posedge i_mclk);
        #1;
        if (ev == 10'h004) begin
            i_req = 1'b0;
            chk({15'h0, o_global_bus_request}, 16'h0001);
            n = 0;
            while (o_sel_global !== 1'b1 && n < 40) begin
                @(posedge i_mclk);
                #1;
                n++;
            end
            // A stale grant from the previous access must not shorten the wait.
            chk({15'h0, (n > lat)}, 16'h0001);
        end
        chk({6'h0, sv}, {6'h0, ev});
        chk(o_addr, a);
        chk({15'h0, o_we}, {15'h0, we});
        if (we) chk(o_wdata, i_wdata);
        if (ev == 10'h020) chk({13'h0, o_periph}, {13'h0, ep});
    endtask : go

    task rd(input logic [15:0] a, input logic [9:0] ev, input periph_t ep);
        go(SPACE_DATA, a, 1'b0, ev, ep);
    endtask : rd

    task wr5(input logic [15:0] d);
        i_wdata = d;
        go(SPACE_DATA, 16'h0005, 1'b1, 10'h080, PER_NONE);
    endtask : wr5

    // ----------------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------------
    initial begin
        i_rst_b = 1'b0; i_ce = 1'b1; i_req = 1'b0; i_space = SPACE_DATA;
        i_addr = 16'h0000; i_we = 1'b0; i_wdata = 16'h0000; i_cnf = 1'b0; lat = 4'h0;
        repeat (8) @(posedge i_mclk);
        chk({15'h0, o_ready}, 16'h0001);
        chk(o_global_alloc_reg, 16'h0000);
        #1 i_rst_b = 1'b1;
        rd(16'h0000, 10'h080, PER_NONE);
        rd(16'h005f, 10'h080, PER_NONE);
        rd(16'h0060, 10'h040, PER_NONE);
        rd(16'h0080, 10'h002, PER_NONE);
        rd(16'h0200, 10'h040, PER_NONE);
        rd(16'h03ff, 10'h040, PER_NONE);
        rd(16'h0400, 10'h002, PER_NONE);
        rd(16'h0800, 10'h001, PER_NONE);
        rd(16'h6fff, 10'h001, PER_NONE);
        rd(16'h7000, 10'h001, PER_NONE);
        rd(16'h7010, 10'h020, PER_SYS);
        rd(16'h702f, 10'h020, PER_WDOG);
        rd(16'h7030, 10'h020, PER_ADC);
        rd(16'h7040, 10'h020, PER_SPI);
        rd(16'h7050, 10'h020, PER_SCI);
        rd(16'h7060, 10'h001, PER_NONE);
        rd(16'h7070, 10'h020, PER_XINT);
        rd(16'h709f, 10'h020, PER_DIO);
        rd(16'h70a0, 10'h001, PER_NONE);
        rd(16'h7400, 10'h010, PER_NONE);
        rd(16'h743f, 10'h010, PER_NONE);
        rd(16'h7440, 10'h002, PER_NONE);
        rd(16'h7800, 10'h001, PER_NONE);
        rd(16'hffff, 10'h008, PER_NONE);
        i_cnf = 1'b1;
        rd(16'h0200, 10'h002, PER_NONE);
        i_cnf = 1'b0;
        go(SPACE_PROG, 16'h7010, 1'b0, 10'h200, PER_NONE);
        go(SPACE_IO, 16'h0005, 1'b0, 10'h100, PER_NONE);
        wr5(16'h00ff);
        rd(16'h0005, 10'h080, PER_NONE);
        chk(o_rdata, 16'h00ff);
        chk({15'h0, o_rdata_valid}, 16'h0001);
        rd(16'hfe00, 10'h008, PER_NONE);
        rd(16'hff10, 10'h004, PER_NONE);
        lat = 4'h9;
        wr5(16'h0080);
        rd(16'h8000, 10'h004, PER_NONE);
        go(SPACE_DATA, 16'h9000, 1'b1, 10'h004, PER_NONE);
        rd(16'h7fff, 10'h001, PER_NONE);
        wr5(16'h007f);
        rd(16'hffff, 10'h008, PER_NONE);
        // Clock enable low must freeze the last pulse and the routed address.
        i_ce = 1'b0;
        i_addr = 16'h0060;
        @(posedge i_mclk);
        #1;
        chk({6'h0, sv}, 16'h0008);
        chk(o_addr, 16'hffff);
        i_ce = 1'b1;
        results;
    end

    initial begin
        #20000;
        n_mismatch++;
        results;
    end
endmodule : data_space_address_decoder_bench
